// file: hdl/dsau_pkg.sv
// Package of constants for the data space access unit
// Contract
// R01 - Effective data addresses are 16-bit byte addresses: 64 Kbytes, 32K words.
// R02 - Read page extends reads, write page extends writes, to 16 Mbytes.
// R03 - At most 52 Kbytes implemented: 4 Kbytes SFR plus 48 Kbytes RAM.
// R04 - Accesses outside implemented memory read back all zeros.
// R05 - Low byte at even address, high byte at next odd address.
// R06 - Post-modified pointer advances by one for bytes, two for words.
// R07 - Byte read fetches whole word, address bit 0 picks lane, placed low.
// R08 - Word-wide decode with per-lane write strobes for byte writes.
// R09 - Word accesses must be even; misaligned word access raises address error.
// R10 - Misaligned read completes; misaligned write suppresses update; then trap.
// R11 - Byte load into working register replaces low byte, keeps high byte.
// R12 - Sign-extend and zero-extend operations on working register low byte.
// R13 - SFRs occupy 0x0000 to 0x0FFF; unused SFR addresses read zero.
// R14 - Addresses 0x0000 to 0x1FFF reachable by 13-bit direct field.
// R15 - Whole data space reachable by 16-bit direct field or pointer.
// R16 - Separate read and write address generators form addresses independently.
// R17 - Address error reported to exception logic in the detecting cycle; here the trap is registered and shows on the next cycle.
`default_nettype none
package dsau_pkg;
	localparam int EA_W       = 16;
	localparam int PAGE_W     = 8;
	localparam int XADDR_W    = EA_W + PAGE_W;
	localparam int SFR_BYTES  = 4096;
	localparam int RAM_BYTES  = 49152;
	localparam int DATA_BYTES = SFR_BYTES + RAM_BYTES;
	localparam int NEAR_W     = 13;
	localparam logic [EA_W-1:0] SFR_LAST  = 16'h0fff;
	localparam logic [EA_W-1:0] NEAR_LAST = 16'h1fff;
	localparam logic [EA_W-1:0] STEP_BYTE = 16'h0001;
	localparam logic [EA_W-1:0] STEP_WORD = 16'h0002;
	localparam logic [PAGE_W-1:0] PAGE_RST = 8'h01;
	typedef enum logic [1:0]
	{
		DSAU_MODE_PTR    = 2'b00,
		DSAU_MODE_DIR16  = 2'b01,
		DSAU_MODE_NEAR13 = 2'b11
	} dsau_amode_t;
	typedef enum logic [1:0]
	{
		DSAU_EXT_NONE = 2'b00,
		DSAU_EXT_SIGN = 2'b01,
		DSAU_EXT_ZERO = 2'b11
	} dsau_ext_t;
endpackage
`default_nettype wire

// file: hdl/dsau_agen.sv
// One address generator: effective address and pointer post-modify
`default_nettype none
module dsau_agen
	import dsau_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  valid,
	input  wire dsau_pkg::dsau_amode_t mode,
	input  wire logic [15:0]           field,
	input  wire logic [15:0]           pointer,
	input  wire logic                  isByte,
	input  wire logic                  postInc,
	input  wire logic [7:0]            page,
	output logic      [15:0]           ea,
	output logic      [23:0]           xaddr,
	output logic      [15:0]           nxtPointer,
	output logic                       misaligned
);
	always_comb
	begin
		case (mode)
			DSAU_MODE_NEAR13: ea = {3'h0, field[NEAR_W-1:0]}; // [R14]
			DSAU_MODE_DIR16:  ea = field; // [R15]
			DSAU_MODE_PTR:    ea = pointer; // [R15]
			default:          ea = pointer;
		endcase
	end
	assign xaddr = {page, ea}; // [R02]
	assign nxtPointer = !postInc ? pointer
		: pointer + (isByte ? STEP_BYTE : STEP_WORD); // [R06]
	assign misaligned = valid && !isByte && ea[0]; // [R09]
	logic unusedTie;
	assign unusedTie = core_clk ^ sys_rst;
endmodule
`default_nettype wire

// file: hdl/dsau_top.sv
// Data space access unit: read/write paths, lanes, zero fill, address error
`default_nettype none
module dsau_top
	import dsau_pkg::*;
#(
	parameter int RAM_SIZE = dsau_pkg::RAM_BYTES
)
(
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  rdValid,
	input  wire dsau_pkg::dsau_amode_t rdMode,
	input  wire logic [15:0]           rdField,
	input  wire logic [15:0]           rdPointer,
	input  wire logic                  rdByte,
	input  wire logic                  rdPostInc,
	input  wire logic [3:0]            rdDest,
	input  wire logic                  wrValid,
	input  wire dsau_pkg::dsau_amode_t wrMode,
	input  wire logic [15:0]           wrField,
	input  wire logic [15:0]           wrPointer,
	input  wire logic                  wrByte,
	input  wire logic                  wrPostInc,
	input  wire logic [15:0]           wrData,
	input  wire logic                  pageWrEn,
	input  wire logic                  pageSelWrite,
	input  wire logic [7:0]            pageData,
	input  wire logic                  extValid,
	input  wire dsau_pkg::dsau_ext_t   extOp,
	input  wire logic [3:0]            extReg,
	input  wire logic [15:0]           sfrRdData,
	input  wire logic                  sfrHit,
	output logic                       rdDone_ff,
	output logic      [15:0]           rdData_ff,
	output logic      [15:0]           rdPtrNext_ff,
	output logic      [15:0]           wrPtrNext_ff,
	output logic      [23:0]           rdXaddr_ff,
	output logic      [23:0]           wrXaddr_ff,
	output logic                       sfrWrEn_ff,
	output logic      [1:0]            sfrWrLane_ff,
	output logic      [15:0]           sfrWrAddr_ff,
	output logic      [15:0]           sfrWrData_ff,
	output logic      [7:0]            readPage_ff,
	output logic      [7:0]            writePage_ff,
	output logic                       addrErrTrap_ff,
	output logic                       addrErrWrite_ff,
	output logic      [15:0]           workReg0_ff
);
	localparam int RAM_WORDS = RAM_SIZE / 2;
	localparam int RAM_AW = $clog2(RAM_WORDS);
	localparam logic [15:0] RAM_BASE = 16'(SFR_BYTES);
	localparam logic [16:0] DATA_END = 17'(SFR_BYTES + RAM_SIZE);

	// Refuse sizes that the word index or the zero fill cannot serve
	if (RAM_SIZE < 4 || RAM_SIZE > RAM_BYTES || RAM_SIZE % 2 != 0)
	begin : g_bad_ram_size
		$error("RAM_SIZE must be even, from 4 bytes to 48 Kbytes");
	end
	// The ports are written at these widths
	if (EA_W != 16 || PAGE_W != 8 || XADDR_W != 24)
	begin : g_bad_widths
		$error("Package address widths do not match the ports");
	end
	// Near window must match its field; RAM sits right above the SFRs
	if (NEAR_LAST != 16'((1 << NEAR_W) - 1)
		|| SFR_LAST != 16'(SFR_BYTES - 1))
	begin : g_bad_windows
		$error("SFR or near window limits are inconsistent");
	end
	// Never more than the SFR window plus the largest RAM [R03]
	if (DATA_BYTES != SFR_BYTES + RAM_BYTES)
	begin : g_bad_total
		$error("Implemented data memory total is inconsistent");
	end

	// All control state; pulses are rebuilt from the inputs every cycle
	typedef struct packed {
		logic        rdDone;
		logic [15:0] rdData;
		logic [15:0] rdPtrNext;
		logic [15:0] wrPtrNext;
		logic [23:0] rdXaddr;
		logic [23:0] wrXaddr;
		logic        sfrWrEn;
		logic [1:0]  sfrWrLane;
		logic [15:0] sfrWrAddr;
		logic [15:0] sfrWrData;
		logic [7:0]  readPage;
		logic [7:0]  writePage;
		logic        trap;
		logic        trapWrite;
		logic [15:0][15:0] workRegs;
	} dsau_state_t;

	dsau_state_t st_ff;
	dsau_state_t nxt_st;

	// RAM kept outside the struct: too large to reset and not control state
	logic [1:0][7:0] ramMem [RAM_WORDS];

	logic [15:0] rdEa;
	logic [15:0] wrEa;
	logic [23:0] rdX;
	logic [23:0] wrX;
	logic [15:0] rdPtrN;
	logic [15:0] wrPtrN;
	logic        rdMis;
	logic        wrMis;

	// Two generators so read and write addresses never share logic [R16]
	dsau_agen rdGen
	(
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.valid      (rdValid),
		.mode       (rdMode),
		.field      (rdField),
		.pointer    (rdPointer),
		.isByte     (rdByte),
		.postInc    (rdPostInc),
		.page       (st_ff.readPage),
		.ea         (rdEa),
		.xaddr      (rdX),
		.nxtPointer (rdPtrN),
		.misaligned (rdMis)
	);

	dsau_agen wrGen
	(
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.valid      (wrValid),
		.mode       (wrMode),
		.field      (wrField),
		.pointer    (wrPointer),
		.isByte     (wrByte),
		.postInc    (wrPostInc),
		.page       (st_ff.writePage),
		.ea         (wrEa),
		.xaddr      (wrX),
		.nxtPointer (wrPtrN),
		.misaligned (wrMis)
	);

	function automatic logic inRam(input logic [15:0] a);
		inRam = a >= RAM_BASE && {1'b0, a} < DATA_END; // [R03]
	endfunction

	function automatic logic [RAM_AW-1:0] ramIdx(input logic [15:0] a);
		logic [15:0] off;
		off = a - RAM_BASE;
		ramIdx = off[RAM_AW:1];
	endfunction

	function automatic logic isSfr(input logic [15:0] a);
		isSfr = a <= SFR_LAST; // [R13]
	endfunction

	// Word accesses enable both lanes, byte accesses only their own
	function automatic logic [1:0] laneMask(input logic isByte,
		input logic a0);
		if (!isByte)
			laneMask = 2'b11;
		else if (a0)
			laneMask = 2'b10; // [R05]
		else
			laneMask = 2'b01; // [R05]
	endfunction

	// Byte lane chosen by address bit 0, handed over on the low lane
	function automatic logic [7:0] pickLane(input logic [15:0] w,
		input logic a0);
		pickLane = a0 ? w[15:8] : w[7:0]; // [R05] [R07]
	endfunction

	// High byte after an extend; unknown codes leave it alone
	function automatic logic [7:0] extHigh(input dsau_ext_t op,
		input logic [15:0] w);
		case (op)
			DSAU_EXT_SIGN: extHigh = {8{w[7]}}; // [R12]
			DSAU_EXT_ZERO: extHigh = 8'h00; // [R12]
			default:       extHigh = w[15:8];
		endcase
	endfunction

	logic              rdIsRam;
	logic              rdIsSfr;
	logic              wrIsRam;
	logic              wrIsSfr;
	logic [RAM_AW-1:0] rdIdx;
	logic [RAM_AW-1:0] wrIdx;
	logic [15:0]       ramWord;
	logic [15:0]       rdWord;
	logic [7:0]        rdLane;
	logic [15:0]       rdResult;
	logic [1:0]        wrLanes;
	logic [7:0]        wrHiByte;
	logic              wrGo;

	assign rdIsSfr = isSfr(rdEa);
	assign rdIsRam = inRam(rdEa);
	assign wrIsSfr = isSfr(wrEa);
	assign wrIsRam = inRam(wrEa);
	// One index per side; the lanes share the word decode [R08]
	assign rdIdx = ramIdx(rdEa);
	assign wrIdx = ramIdx(wrEa);
	assign ramWord = {ramMem[rdIdx][1], ramMem[rdIdx][0]};
	// Suppress the update but let the instruction run on [R10]
	assign wrGo = wrValid && !wrMis;
	assign wrLanes = laneMask(wrByte, wrEa[0]); // [R08]
	// A byte write always arrives on the low data lane
	assign wrHiByte = wrByte ? wrData[7:0] : wrData[15:8];

	always_comb
	begin
		// Word fetch even for byte reads; unmapped gives zero [R04] [R07]
		if (rdIsSfr)
			rdWord = sfrHit ? sfrRdData : 16'h0000; // [R13]
		else if (rdIsRam)
			rdWord = ramWord;
		else
			rdWord = 16'h0000; // [R04]
		rdLane = pickLane(rdWord, rdEa[0]); // [R07]
		rdResult = rdByte ? {8'h00, rdLane} : rdWord; // [R07]
	end

	always_ff @(posedge core_clk)
	begin
		if (wrGo && wrIsRam)
		begin
			if (wrLanes[0])
				ramMem[wrIdx][0] <= wrData[7:0]; // [R05]
			if (wrLanes[1])
				ramMem[wrIdx][1] <= wrHiByte; // [R05]
		end
	end

	// Pulses clear themselves; read data, address and pointer outputs hold until the next request; the SFR write bus, write data included, is rebuilt every cycle
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rdDone = rdValid;
		nxt_st.trap = rdMis || wrMis; // [R09] [R17]
		nxt_st.trapWrite = wrMis; // [R10]
		nxt_st.sfrWrEn = wrGo && wrIsSfr;
		nxt_st.sfrWrLane = wrLanes; // [R08]
		nxt_st.sfrWrAddr = {wrEa[15:1], 1'b0};
		// A byte write shows its byte on both lanes; strobes pick one [R05]
		nxt_st.sfrWrData = {wrHiByte, wrData[7:0]};
		if (rdValid)
		begin
			nxt_st.rdData = rdResult;
			nxt_st.rdXaddr = rdX; // [R01] [R02]
			nxt_st.rdPtrNext = rdPtrN; // [R06]
			// Misaligned read still completes into its target [R10]
			if (rdByte)
				nxt_st.workRegs[rdDest][7:0] = rdLane; // [R11]
			else
				nxt_st.workRegs[rdDest] = rdWord;
		end
		if (wrValid)
		begin
			nxt_st.wrXaddr = wrX; // [R02]
			nxt_st.wrPtrNext = wrPtrN; // [R06]
		end
		// Extends act on the register as it stood before this edge
		if (extValid)
			nxt_st.workRegs[extReg][15:8] = extHigh(extOp,
				st_ff.workRegs[extReg]); // [R12]
		if (pageWrEn)
		begin
			if (pageSelWrite)
				nxt_st.writePage = pageData; // [R02]
			else
				nxt_st.readPage = pageData; // [R02]
		end
	end

	function automatic dsau_state_t rstState();
		rstState = '0;
		rstState.readPage = PAGE_RST; // [R02]
		rstState.writePage = PAGE_RST; // [R02]
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			st_ff <= rstState();
		else
			st_ff <= nxt_st;
	end

	// Every output is a bare state register
	assign rdDone_ff       = st_ff.rdDone;
	assign rdData_ff       = st_ff.rdData;
	assign rdPtrNext_ff    = st_ff.rdPtrNext;
	assign wrPtrNext_ff    = st_ff.wrPtrNext;
	assign rdXaddr_ff      = st_ff.rdXaddr;
	assign wrXaddr_ff      = st_ff.wrXaddr;
	assign sfrWrEn_ff      = st_ff.sfrWrEn;
	assign sfrWrLane_ff    = st_ff.sfrWrLane;
	assign sfrWrAddr_ff    = st_ff.sfrWrAddr;
	assign sfrWrData_ff    = st_ff.sfrWrData;
	assign readPage_ff     = st_ff.readPage;
	assign writePage_ff    = st_ff.writePage;
	assign addrErrTrap_ff  = st_ff.trap;
	assign addrErrWrite_ff = st_ff.trapWrite;
	assign workReg0_ff     = st_ff.workRegs[0];
endmodule
`default_nettype wire

// file: sim/dsau_top_assertions.sv
// Port-level checker of the data space access unit
`default_nettype none
module dsau_top_assertions
	import dsau_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              sys_rst,
	input wire logic              rdValid,
	input wire dsau_amode_t       rdMode,
	input wire logic [15:0]       rdPointer,
	input wire logic              rdByte,
	input wire logic              rdPostInc,
	input wire logic              wrValid,
	input wire dsau_amode_t       wrMode,
	input wire logic [15:0]       wrPointer,
	input wire logic              wrByte,
	input wire logic              pageWrEn,
	input wire logic              rdDone_ff,
	input wire logic [15:0]       rdPtrNext_ff,
	input wire logic [23:0]       rdXaddr_ff,
	input wire logic [7:0]        readPage_ff,
	input wire logic              sfrWrEn_ff,
	input wire logic              addrErrTrap_ff,
	input wire logic              addrErrWrite_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence misRd;
		rdValid && !rdByte && rdMode == DSAU_MODE_PTR && rdPointer[0];
	endsequence
	sequence misWr;
		wrValid && !wrByte && wrMode == DSAU_MODE_PTR && wrPointer[0];
	endsequence
	rd_done_a: assert property (rdValid |=> rdDone_ff)
		else $error("read not answered");
	rd_quiet_a: assert property (!rdValid |=> !rdDone_ff)
		else $error("read done without request");
	rd_trap_a: assert property (misRd |=> addrErrTrap_ff)
		else $error("misaligned read without trap");
	wr_suppress_a: assert property (misWr |=>
		addrErrTrap_ff && addrErrWrite_ff && !sfrWrEn_ff)
		else $error("misaligned write not suppressed");
	byte_ok_a: assert property (rdValid && rdByte && !wrValid
		|=> !addrErrTrap_ff) else $error("trap on byte read");
	ptr_step_a: assert property (rdValid && rdPostInc &&
		rdMode == DSAU_MODE_PTR |=> rdPtrNext_ff == $past(rdPointer)
		+ ($past(rdByte) ? STEP_BYTE : STEP_WORD))
		else $error("pointer step wrong");
	page_hold_a: assert property (!pageWrEn |=>
		$stable(readPage_ff)) else $error("page moved");
	xaddr_page_a: assert property (rdValid && !pageWrEn |=>
		rdXaddr_ff[23:16] == $past(readPage_ff))
		else $error("page not in extended address");
endmodule
bind dsau_top dsau_top_assertions u_dsau_top_assertions (.*);
`default_nettype wire

// file: sim/dsau_sfr_model.sv
// Stand-in for the peripheral registers behind the SFR window
`default_nettype none
module dsau_sfr_model
	import dsau_pkg::*;
(
	input  wire logic [1:0]  mode,
	input  wire logic [15:0] field,
	input  wire logic [15:0] pointer,
	output logic             hit,
	output logic [15:0]      data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ea;
	// Near form keeps only the low 13 bits
	assign ea = (mode == 2'b00) ? pointer :
		(mode == 2'b11) ? {3'h0, field[12:0]} : field;
	// One live word; a miss shows the inverse, never zero
	assign hit = (ea[15:1] == 15'h0400);
	assign data = hit ? 16'h5aa5 : 16'ha55a;
endmodule
`default_nettype wire

// file: sim/tb_dsau_top.sv
// Self-checking bench of the data space access unit
`default_nettype none
module tb_dsau_top;
	import dsau_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] P = DSAU_MODE_PTR;
	logic        core_clk = 0;
	logic        sys_rst = 1;
	logic        rdValid = 0;
	logic        wrValid = 0;
	logic        by = 0;
	logic        pageWrEn = 0;
	logic        pageSel = 0;
	logic        extValid = 0;
	logic [1:0]  md = 0;
	logic [1:0]  xo = 0;
	logic [7:0]  pageData = 0;
	logic [15:0] ad = 0;
	logic [15:0] wD = 0;
	logic [15:0] sD;
	logic        sHit;
	logic        done;
	logic        sWe;
	logic        trap;
	logic [1:0]  lane;
	logic [7:0]  rPg;
	logic [15:0] rD, pN, sA, w0;
	logic [23:0] rX, wX;
	logic        pi = 1;
	logic [3:0]  dst = 0;
	logic        tWr;
	logic [7:0]  wPg;
	logic [15:0] wN, sWd;
	int          bad_count = 0;
	int          checks_done = 0;
	always #2 core_clk = ~core_clk;
	dsau_top #(.RAM_SIZE(4096)) u_dsau_top (.core_clk(core_clk),
		.sys_rst(sys_rst), .rdValid(rdValid), .rdMode(dsau_amode_t'(md)),
		.rdField(ad), .rdPointer(ad), .rdByte(by), .rdPostInc(pi),
		.rdDest(dst), .wrValid(wrValid), .wrMode(dsau_amode_t'(md)),
		.wrField(ad), .wrPointer(ad), .wrByte(by), .wrPostInc(pi),
		.wrData(wD), .pageWrEn(pageWrEn), .pageSelWrite(pageSel),
		.pageData(pageData), .extValid(extValid),
		.extOp(dsau_ext_t'(xo)), .extReg(dst), .sfrRdData(sD),
		.sfrHit(sHit), .rdDone_ff(done), .rdData_ff(rD),
		.rdPtrNext_ff(pN), .wrPtrNext_ff(wN), .rdXaddr_ff(rX),
		.wrXaddr_ff(wX), .sfrWrEn_ff(sWe), .sfrWrLane_ff(lane),
		.sfrWrAddr_ff(sA), .sfrWrData_ff(sWd), .readPage_ff(rPg),
		.writePage_ff(wPg), .addrErrTrap_ff(trap),
		.addrErrWrite_ff(tWr), .workReg0_ff(w0));
	dsau_sfr_model u_dsau_sfr_model (.mode(md), .field(ad),
		.pointer(ad), .hit(sHit), .data(sD));
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// One request, then sample just after the answering edge
	task automatic op(input logic w, input logic [1:0] m,
		input logic [15:0] a, input logic b, input logic [15:0] d);
		@(posedge core_clk);
		{rdValid, wrValid, md, ad, by, wD} <= {!w, w, m, a, b, d};
		@(posedge core_clk);
		{rdValid, wrValid} <= 2'b00;
		#1;
	endtask
	task automatic pg(input logic s, input logic [7:0] v);
		@(posedge core_clk);
		{pageWrEn, pageSel, pageData} <= {1'b1, s, v};
		@(posedge core_clk);
		pageWrEn <= 0;
		#1;
	endtask
	task automatic ex(input logic [1:0] o);
		@(posedge core_clk);
		{extValid, xo} <= {1'b1, o};
		@(posedge core_clk);
		extValid <= 0;
		#1;
	endtask
	// Post-increment and target register, held until changed again
	task automatic knobs(input logic p, input logic [3:0] d);
		@(posedge core_clk);
		{pi, dst} <= {p, d};
		#1;
	endtask
	task automatic t_lanes();
		chk(rPg, 8'h01);
		op(1, P, 16'h1000, 0, 16'h1234);
		chk(wN, 16'h1002);
		op(0, P, 16'h1000, 0, 0);
		chk(rD, 16'h1234);
		op(0, P, 16'h1001, 1, 0);
		chk(rD, 16'h0012);
		chk(pN, 16'h1002);
		op(1, P, 16'h1000, 1, 16'h77ab);
		chk(wN, 16'h1001);
		op(0, P, 16'h1000, 0, 0);
		chk(rD, 16'h12ab);
		$display("test lanes done");
	endtask
	task automatic t_fill();
		op(0, P, 16'h2000, 0, 0);
		chk(rD, 16'h0000);
		op(0, P, 16'h0800, 0, 0);
		chk(rD, 16'h5aa5);
		op(0, P, 16'h0801, 1, 0);
		chk(rD, 16'h005a);
		op(0, P, 16'h0802, 0, 0);
		chk(rD, 16'h0000);
		op(1, P, 16'h0801, 1, 16'h00c3);
		chk({sWe, lane, sA}, {1'b1, 2'b10, 16'h0800});
		chk(sWd, 16'hc3c3);
		$display("test fill done");
	endtask
	task automatic t_align();
		op(1, P, 16'h1001, 0, 16'hffff);
		chk(trap, 1'b1);
		chk(tWr, 1'b1);
		op(1, P, 16'h0803, 0, 16'h1111);
		chk({sWe, trap}, 2'b01);
		op(0, P, 16'h1000, 0, 0);
		chk(rD, 16'h12ab);
		op(0, P, 16'h1001, 0, 0);
		chk({done, trap}, 2'b11);
		chk(tWr, 1'b0);
		$display("test align done");
	endtask
	task automatic t_page();
		pg(0, 8'h05);
		pg(1, 8'h09);
		chk({rPg, wPg}, 16'h0509);
		op(0, DSAU_MODE_NEAR13, 16'hf000, 0, 0);
		chk(rX, 24'h051000);
		op(1, DSAU_MODE_DIR16, 16'h1ffe, 0, 16'h9999);
		chk(wX, 24'h091ffe);
		op(0, DSAU_MODE_DIR16, 16'h1ffe, 0, 0);
		chk({rD, rX[7:0]}, 24'h9999fe);
		op(1, DSAU_MODE_NEAR13, 16'hf002, 0, 16'h4321);
		chk(wX, 24'h091002);
		op(0, DSAU_MODE_DIR16, 16'h1002, 0, 0);
		chk(rD, 16'h4321);
		$display("test page done");
	endtask
	task automatic t_ext();
		op(0, P, 16'h1000, 0, 0);
		op(0, P, 16'h1001, 1, 0);
		chk(w0, 16'h1212);
		ex(DSAU_EXT_SIGN);
		chk(w0, 16'h0012);
		op(0, P, 16'h1000, 1, 0);
		ex(DSAU_EXT_SIGN);
		chk(w0, 16'hffab);
		ex(DSAU_EXT_ZERO);
		chk(w0, 16'h00ab);
		knobs(0, 4'h1);
		op(0, P, 16'h1000, 0, 0);
		chk(w0, 16'h00ab);
		chk(pN, 16'h1000);
		op(1, P, 16'h1002, 1, 16'h0055);
		chk(wN, 16'h1002);
		op(0, P, 16'h1002, 0, 0);
		chk(rD, 16'h4355);
		ex(DSAU_EXT_SIGN);
		chk(w0, 16'h00ab);
		knobs(1, 4'h0);
		$display("test ext done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Cuts a hang short at 25000 cycles, far beyond the length of the tests
	initial
	begin
		#100000;
		bad_count++;
		close_out();
	end
	initial
	begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 0;
		#1;
		t_lanes();
		t_fill();
		t_align();
		t_page();
		t_ext();
		close_out();
	end
endmodule
`default_nettype wire
